// ===== verilog/frame_pkg.sv
// frame_pkg: constants for the serial command frame decoder
// assumes: one 25 MHz clock, synchronous active-high reset
package frame_pkg;
	// ********************************
	// frame layout
	// ********************************
	localparam int FRAME_BITS    = 24;
	localparam int DIR_POS       = 23;
	localparam int ZERO_POS      = 22;
	localparam int SEL_HI        = 21;
	localparam int SEL_LO        = 19;
	localparam int ADDR_HI       = 18;
	localparam int ADDR_LO       = 16;
	localparam int DATA_HI       = 15;
	localparam int DATA_W        = 16;
	localparam int CODE_HI       = 15;
	localparam int CODE_LO       = 4;
	localparam int CODE_W        = 12;
	localparam int NUM_CH        = 4;
	localparam int CNT_W         = 5;
	localparam logic [4:0] CNT_FULL = 5'h18;
	// ********************************
	// target selects and channel addresses
	// ********************************
	localparam logic [2:0] SEL_CODE  = 3'h0;
	localparam logic [2:0] SEL_RANGE = 3'h1;
	localparam logic [2:0] SEL_POWER = 3'h2;
	localparam logic [2:0] SEL_CTRL  = 3'h3;
	localparam logic [2:0] ADDR_ALL  = 3'h4;
	// ********************************
	// coding
	// ********************************
	localparam logic [1:0] COD_OFFSET = 2'h0;
	localparam logic [1:0] COD_TWOS   = 2'h1;
	localparam logic [1:0] COD_STRAIGHT = 2'h2;
	localparam logic [11:0] CODE_OFFSET = 12'h800;
	localparam logic [15:0] REG_RESET   = 16'h0000;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} rx_state_t;
endpackage : frame_pkg

// ===== verilog/code_convert.sv
// code_convert: maps a 12-bit channel code to a signed level
// assumes: coding select is stable while the code is used
`timescale 1ns/1ps
module code_convert (
	input  wire logic [1:0]          coding,
	input  wire logic [11:0]         code,
	output logic signed [12:0]       level
);
	import frame_pkg::*;
	always_comb begin
		case (coding)
			COD_OFFSET:   level = $signed({1'b0, code}) - $signed({1'b0, CODE_OFFSET}); // RQ9
			COD_TWOS:     level = $signed({code[11], code});                             // RQ10
			default:      level = $signed({1'b0, code});                                 // RQ11
		endcase
	end
endmodule : code_convert

// ===== verilog/frame_decoder.sv
// frame_decoder: receives and executes 24-bit serial command frames
// assumes: serial_data_in and frame_sel_n synchronous to ref_clk, shift_en marks a bit
// assumes: frame_sel_n returns high for at least one cycle between frames
// assumes: coding is a static strap, clk_en held high to run
// Functional notes
// RQ1: frames are exactly 24 bits, shifted in
// RQ2: host sends bit 22 as zero
// RQ3: bits arrive most significant bit first
// RQ4: bit 23 selects read or write
// RQ5: bits 21-19 select target register
// RQ6: bits 18-16 select channel or all
// RQ7: bits 15-0 are the data field
// RQ8: every target writable and readable back
// RQ9: offset binary code minus 2048
// RQ10: twos complement code is signed
// RQ11: unipolar code is straight binary
// RQ12: channel code sits in bits 15-4
// RQ13: act only on full frame at deselect
`timescale 1ns/1ps
module frame_decoder (
	input  wire logic                          ref_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          clk_en,
	input  wire logic                          frame_sel_n,
	input  wire logic                          shift_en,
	input  wire logic                          serial_data_in,
	input  wire logic [1:0]                    coding,
	output logic [frame_pkg::CODE_W-1:0]       ch_code [frame_pkg::NUM_CH],
	output logic signed [12:0]                 ch_level [frame_pkg::NUM_CH],
	output logic [frame_pkg::DATA_W-1:0]       range_reg,
	output logic [frame_pkg::DATA_W-1:0]       power_reg,
	output logic [frame_pkg::DATA_W-1:0]       ctrl_reg,
	output logic [frame_pkg::DATA_W-1:0]       read_data,
	output logic                               read_valid,
	output logic                               frame_done,
	output logic                               frame_error
);
	import frame_pkg::*;

	// ********************************
	// receive state
	// ********************************
	rx_state_t               state_r, state_nxt;
	logic [FRAME_BITS-1:0]   shift_r, shift_nxt;
	logic [CNT_W-1:0]        cnt_r, cnt_nxt;
	logic                    exec;
	logic                    bad;

	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		cnt_nxt   = cnt_r;
		exec      = 1'b0;
		bad       = 1'b0;
		case (state_r)
			ST_IDLE: begin
				cnt_nxt = '0;
				if (!frame_sel_n) begin
					state_nxt = ST_SHIFT;
					if (shift_en) begin
						shift_nxt = {shift_r[FRAME_BITS-2:0], serial_data_in}; // RQ3
						cnt_nxt   = 5'h01;
					end
				end
			end
			ST_SHIFT: begin
				if (frame_sel_n) begin
					state_nxt = ST_IDLE;
					cnt_nxt   = '0;
					if (cnt_r == CNT_FULL) begin
						exec = 1'b1; // RQ13
					end else begin
						bad = 1'b1; // RQ13
					end
				end else if (shift_en) begin
					shift_nxt = {shift_r[FRAME_BITS-2:0], serial_data_in}; // RQ1 RQ3
					if (cnt_r != 5'h1f) begin
						cnt_nxt = cnt_r + 5'h01;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt   = '0;
			end
		endcase
	end

	// ********************************
	// receive registers
	// ********************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			shift_r <= '0;
			cnt_r   <= '0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// ********************************
	// field decode
	// ********************************
	logic              is_read;
	logic [2:0]        sel;
	logic [2:0]        addr;
	logic [DATA_W-1:0] data;
	assign is_read = shift_r[DIR_POS];          // RQ4
	assign sel     = shift_r[SEL_HI:SEL_LO];     // RQ5
	assign addr    = shift_r[ADDR_HI:ADDR_LO];   // RQ6
	assign data    = shift_r[DATA_HI:0];         // RQ7

	// ********************************
	// command decode
	// ********************************
	logic              wr_en;
	logic              rd_en;
	assign wr_en   = exec && !is_read;           // RQ4
	assign rd_en   = exec && is_read;            // RQ4

	// ********************************
	// register store
	// ********************************
	logic [CODE_W-1:0] code_r [NUM_CH];
	logic [CODE_W-1:0] code_nxt [NUM_CH];
	logic [DATA_W-1:0] range_r, range_nxt, power_r, power_nxt, ctrl_r, ctrl_nxt;
	logic [DATA_W-1:0] rd_r, rd_nxt;
	logic              rv_r, rv_nxt, done_r, done_nxt, err_r, err_nxt;
	logic [1:0]        ch_idx;
	assign ch_idx = addr[1:0];

	// ********************************
	// channel codes
	// ********************************
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			always_comb begin
				code_nxt[g] = code_r[g];
				if (wr_en && sel == SEL_CODE && (addr == ADDR_ALL || addr == 3'(g))) begin
					code_nxt[g] = data[CODE_HI:CODE_LO]; // RQ12 RQ6
				end
			end
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					code_r[g] <= '0;
				end else if (clk_en) begin
					code_r[g] <= code_nxt[g];
				end
			end
			assign ch_code[g] = code_r[g];
			code_convert u_conv (
				.coding (coding),
				.code   (code_r[g]),
				.level  (ch_level[g])
			);
		end
	endgenerate

	// ********************************
	// register writes and readback
	// ********************************
	always_comb begin
		range_nxt = range_r;
		power_nxt = power_r;
		ctrl_nxt  = ctrl_r;
		rd_nxt    = rd_r;
		rv_nxt    = 1'b0;
		done_nxt  = exec;
		err_nxt   = bad;
		if (wr_en) begin // RQ8
			case (sel)
				SEL_RANGE: range_nxt = data;
				SEL_POWER: power_nxt = data;
				SEL_CTRL:  ctrl_nxt  = data;
				default:   range_nxt = range_r;
			endcase
		end
		if (rd_en) begin // RQ8
			rv_nxt = 1'b1;
			case (sel)
				SEL_CODE:  rd_nxt = {code_r[ch_idx], 4'h0};
				SEL_RANGE: rd_nxt = range_r;
				SEL_POWER: rd_nxt = power_r;
				SEL_CTRL:  rd_nxt = ctrl_r;
				default:   rd_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			range_r <= REG_RESET;
			power_r <= REG_RESET;
			ctrl_r  <= REG_RESET;
			rd_r    <= '0;
			rv_r    <= 1'b0;
			done_r  <= 1'b0;
			err_r   <= 1'b0;
		end else if (clk_en) begin
			range_r <= range_nxt;
			power_r <= power_nxt;
			ctrl_r  <= ctrl_nxt;
			rd_r    <= rd_nxt;
			rv_r    <= rv_nxt;
			done_r  <= done_nxt;
			err_r   <= err_nxt;
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign range_reg   = range_r;
	assign power_reg   = power_r;
	assign ctrl_reg    = ctrl_r;
	assign read_data   = rd_r;
	assign read_valid  = rv_r;
	assign frame_done  = done_r;
	assign frame_error = err_r;
endmodule : frame_decoder

// ===== tb/host_model.sv
// host_model: host serial port sending frames
// assumes: tb calls send, ref_clk domain
`timescale 1ns/1ps
module host_model (
	input wire logic ref_clk,
	output logic     frame_sel_n,
	output logic     shift_en,
	output logic     serial_data_in
);
	initial begin
		frame_sel_n = 1'b1;
		shift_en = 1'b0;
		serial_data_in = 1'b0;
	end
	task send(input logic [23:0] f, input int n);
		f[22] = 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk) #1;
			frame_sel_n = 1'b0;
			shift_en = 1'b1;
			serial_data_in = (i < 24) ? f[23-i] : 1'b0;
		end
		@(posedge ref_clk) #1;
		frame_sel_n = 1'b1;
		shift_en = 1'b0;
		serial_data_in = ~serial_data_in;
		@(posedge ref_clk) #1;
	endtask : send
endmodule : host_model

// ===== tb/frame_decoder_chk.sv
// frame_decoder_chk: port checks of the decoder
// assumes: bound into frame_decoder, clk_en high
`timescale 1ns/1ps
module frame_decoder_chk (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        frame_sel_n,
	input wire logic [15:0] read_data,
	input wire logic        read_valid,
	input wire logic        frame_done,
	input wire logic        frame_error,
	input wire logic [15:0] range_reg,
	input wire logic [15:0] power_reg,
	input wire logic [15:0] ctrl_reg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_done_after_sel: assert property (frame_done |-> $past(frame_sel_n) && !$past(frame_sel_n, 2))
		else $error("done without deselect");
	a_err_after_sel: assert property (frame_error |-> $past(frame_sel_n) && !$past(frame_sel_n, 2))
		else $error("error without deselect");
	a_done_err_excl: assert property (frame_done |-> !frame_error)
		else $error("done and error together");
	a_done_one_cycle: assert property (frame_done |=> !frame_done)
		else $error("done too long");
	a_err_one_cycle: assert property (frame_error |=> !frame_error)
		else $error("error too long");
	a_read_needs_done: assert property (read_valid |-> frame_done)
		else $error("read without frame");
	a_rdata_holds: assert property (!read_valid |-> $stable(read_data))
		else $error("read data moved");
	a_regs_hold: assert property (!frame_done |-> $stable({range_reg, power_reg, ctrl_reg}))
		else $error("register moved");
	c_read: cover property (read_valid);
	c_write: cover property (frame_done && !read_valid);
	c_error: cover property (frame_error);
endmodule : frame_decoder_chk
bind frame_decoder frame_decoder_chk u_chk (.ref_clk, .sys_rst, .frame_sel_n, .read_data, .read_valid,
	.frame_done, .frame_error, .range_reg, .power_reg, .ctrl_reg);

// ===== tb/tb_top.sv
// tb_top: self-checking bench of the frame decoder
// assumes: host_model drives serial side, clk_en tied high
`timescale 1ns/1ps
module tb_top;
	import frame_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] coding = 2'h0;
	logic frame_sel_n, shift_en, serial_data_in, read_valid, frame_done, frame_error;
	logic [11:0] ch_code [4];
	logic signed [12:0] ch_level [4];
	logic [15:0] range_reg, power_reg, ctrl_reg, read_data;
	int err_count = 0;
	int n_checks = 0;
	always #20 ref_clk = ~ref_clk;
	host_model i_host (.ref_clk, .frame_sel_n, .shift_en, .serial_data_in);
	frame_decoder i_dut (.ref_clk, .sys_rst, .clk_en(1'b1), .frame_sel_n, .shift_en, .serial_data_in, .coding,
		.ch_code, .ch_level, .range_reg, .power_reg, .ctrl_reg, .read_data, .read_valid, .frame_done, .frame_error);
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task conclude();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	task t_regs();
		chk(range_reg, REG_RESET);
		for (int s = 1; s < 4; s++) begin
			i_host.send({2'h0, 3'(s), 3'h0, 16'ha5c3 ^ 16'(s)}, 24);
			chk({15'h0, frame_done}, 16'h1);
			chk(s == 1 ? range_reg : s == 2 ? power_reg : ctrl_reg, 16'ha5c3 ^ 16'(s));
		end
		for (int s = 1; s < 4; s++) begin
			i_host.send({2'h2, 3'(s), 3'h0, 16'h0}, 24);
			chk({14'h0, read_valid, frame_done}, 16'h3);
			chk(read_data, 16'ha5c3 ^ 16'(s));
		end
		chk(range_reg, 16'ha5c2);
	endtask : t_regs
	task t_codes();
		for (int a = 0; a < 4; a++) begin
			i_host.send({5'h0, 3'(a), 12'h3c0 + 12'(a), 4'hf}, 24);
			chk({4'h0, ch_code[a]}, {4'h0, 12'h3c0 + 12'(a)});
		end
		i_host.send(24'h810000, 24);
		chk(read_data, 16'h3c10);
	endtask : t_codes
	task t_levels(input logic [11:0] code, input logic [12:0] o, input logic [12:0] t);
		i_host.send({5'h0, 3'h4, code, 4'h0}, 24);
		for (int c = 0; c < 4; c++) chk({4'h0, ch_code[c]}, {4'h0, code});
		for (int c = 0; c < 4; c++) begin
			@(posedge ref_clk) #1;
			coding = 2'(c);
			#1;
			for (int h = 0; h < 4; h++) begin
				chk({3'h0, ch_level[h]}, {3'h0, c == 0 ? o : c == 1 ? t : {1'b0, code}});
			end
		end
	endtask : t_levels
	task t_bad();
		i_host.send({5'h1, 3'h0, 16'h1234}, 23);
		chk({14'h0, frame_error, frame_done}, 16'h2);
		chk({4'h0, ch_code[0]}, 16'h0);
		i_host.send({5'h1, 3'h0, 16'h1234}, 25);
		chk({14'h0, frame_error, frame_done}, 16'h2);
		chk(power_reg, 16'ha5c1);
		chk(range_reg, 16'ha5c2);
		i_host.send({5'h4, 3'h0, 16'h1234}, 24);
		chk({14'h0, frame_error, frame_done}, 16'h1);
		chk(range_reg, 16'ha5c2);
		chk(power_reg, 16'ha5c1);
		chk(ctrl_reg, 16'ha5c0);
		chk({4'h0, ch_code[0]}, 16'h0);
	endtask : t_bad
	initial begin
		repeat (2) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		t_regs();
		t_codes();
		t_levels(12'hfff, 13'h07ff, 13'h1fff);
		t_levels(12'h800, 13'h0000, 13'h1800);
		t_levels(12'h000, 13'h1800, 13'h0000);
		t_bad();
		conclude();
	end
	initial begin
		#200000;
		err_count++;
		conclude();
	end
endmodule : tb_top
